//--- rtl/hts_ctrl_defines.svh
// register offsets, field positions, reset values and timing figures
// assumes byte wide registers behind the sensor's serial register port
`ifndef HTS_CTRL_DEFINES_SVH
`define HTS_CTRL_DEFINES_SVH
`define HTS_ADDR_DEV_CFG 8'h0e
`define HTS_ADDR_MEAS_CFG 8'h0f
`define HTS_ADDR_MAKER_LO 8'hfc
`define HTS_ADDR_MAKER_HI 8'hfd
`define HTS_ADDR_PART_LO 8'hfe
`define HTS_ADDR_PART_HI 8'hff
`define HTS_BIT_SOFT_RESET 7
`define HTS_RATE_MSB 6
`define HTS_RATE_LSB 4
`define HTS_BIT_HEATER 3
`define HTS_BIT_ALERT_EN 2
`define HTS_BIT_ALERT_POL 1
`define HTS_BIT_ALERT_MODE 0
`define HTS_TEMP_RESOLUTION_MSB 7
`define HTS_TEMP_RESOLUTION_LSB 6
`define HTS_HUMIDITY_RESOLUTION_MSB 5
`define HTS_HUMIDITY_RESOLUTION_LSB 4
`define HTS_BIT_MEAS_RSVD 3
`define HTS_MSEL_MSB 2
`define HTS_MSEL_LSB 1
`define HTS_BIT_TRIGGER 0
`define HTS_DEV_CFG_RST 8'h00
`define HTS_MEAS_CFG_RST 8'h00
`define HTS_CLK_PERIOD_NS 25
`define HTS_MS_IN_NS 1000000
`define HTS_PERIOD_001_MS 17'h1d4c0
`define HTS_PERIOD_010_MS 17'h0ea60
`define HTS_PERIOD_011_MS 17'h02710
`define HTS_PERIOD_100_MS 17'h01388
`define HTS_PERIOD_101_MS 17'h003e8
`define HTS_PERIOD_110_MS 17'h001f4
`define HTS_PERIOD_111_MS 17'h000c8
`endif

//--- rtl/hts_ctrl_pkg.sv
// types shared by the sensor control register block
// assumes the defines header carries the numeric figures other than the enum encodings here
package hts_ctrl_pkg;
  typedef enum logic [2:0] {
    HTS_RATE_OFF = 3'b000,
    HTS_RATE_2MIN = 3'b001,
    HTS_RATE_1MIN = 3'b010,
    HTS_RATE_10S = 3'b011,
    HTS_RATE_5S = 3'b100,
    HTS_RATE_1HZ = 3'b101,
    HTS_RATE_2HZ = 3'b110,
    HTS_RATE_5HZ = 3'b111
  } hts_rate_t;
  typedef enum logic [0:0] {
    HTS_CONV_IDLE = 1'b0,
    HTS_CONV_BUSY = 1'b1
  } hts_conv_state_t;
endpackage : hts_ctrl_pkg

//--- rtl/hts_ctrl_regs.sv
// control and identification registers of the humidity/temperature sensor
// assumes a serial bus front end turns frames into byte register accesses,
// and a conversion engine answers each start with a done pulse
// Function
// - soft reset bit reloads calibration, defaults registers, then self-clears
// - auto rate field resets to 000; 000 means host-triggered only
// - rates 001..100 start conversions every 2min, 1min, 10s, 5s
// - rates 101..111 start conversions at 1, 2 and 5 per second
// - heater bit: 0 off, 1 on, resets to 0
// - alert enable bit: 0 pin high impedance, 1 pin driven, resets 0
// - alert polarity bit: 0 active low, 1 active high, resets 0
// - alert mode bit: 0 level sensitive, 1 comparator, resets 0
// - temperature resolution 00 14-bit, 01 11-bit, 10 9-bit
// - humidity resolution 00 14-bit, 01 11-bit, 10 9-bit, resets 00
// - measurement select 00 humidity and temperature, 01 temperature only
// - trigger write 1 starts conversion, 0 no action, clears when done
// - 16-bit read-only maker code at two consecutive addresses
// - 16-bit read-only part code at the two highest addresses
`timescale 1ns/10ps
`include "hts_ctrl_defines.svh"
module hts_ctrl_regs #(
  parameter int MS_TICK_CYCLES = `HTS_MS_IN_NS / `HTS_CLK_PERIOD_NS,
  parameter logic [15:0] MAKER_CODE = 16'h5a3c, // arbitrary value
  parameter logic [15:0] PART_CODE = 16'h1e2d // arbitrary value
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [7:0] reg_wr_data,
  input wire logic reg_rd_en,
  output logic [7:0] reg_rd_data,
  // conversion engine
  output logic conv_start,
  input wire logic conv_done,
  output logic [1:0] temp_resolution,
  output logic [1:0] humidity_resolution,
  output logic [1:0] measurement_select,
  output logic nvm_reload,
  // heater and alert pin
  output logic heater_on,
  input wire logic alert_active,
  output logic alert_mode,
  output logic alert_pin_out,
  output logic alert_pin_oe_n
);

  logic [7:0] dev_cfg_reg;
  logic [7:0] meas_cfg_reg;
  logic soft_reset_reg;
  hts_ctrl_pkg::hts_conv_state_t conv_state_reg;
  logic [31:0] ms_div_reg;
  logic ms_tick_reg;
  logic [16:0] period_cnt_reg;
  logic auto_tick_reg;
  logic wr_dev;
  logic wr_meas;
  logic trig_set;
  logic soft_clr;
  hts_ctrl_pkg::hts_rate_t rate;
  logic [16:0] period_ms;

  function automatic logic [16:0] rate_period_ms(input hts_ctrl_pkg::hts_rate_t r);
    case (r)
      hts_ctrl_pkg::HTS_RATE_2MIN: rate_period_ms = `HTS_PERIOD_001_MS;
      hts_ctrl_pkg::HTS_RATE_1MIN: rate_period_ms = `HTS_PERIOD_010_MS;
      hts_ctrl_pkg::HTS_RATE_10S: rate_period_ms = `HTS_PERIOD_011_MS;
      hts_ctrl_pkg::HTS_RATE_5S: rate_period_ms = `HTS_PERIOD_100_MS;
      hts_ctrl_pkg::HTS_RATE_1HZ: rate_period_ms = `HTS_PERIOD_101_MS;
      hts_ctrl_pkg::HTS_RATE_2HZ: rate_period_ms = `HTS_PERIOD_110_MS;
      hts_ctrl_pkg::HTS_RATE_5HZ: rate_period_ms = `HTS_PERIOD_111_MS;
      default: rate_period_ms = 17'h00000;
    endcase
  endfunction : rate_period_ms

  always_comb begin
    wr_dev = reg_wr_en && (reg_addr == `HTS_ADDR_DEV_CFG);
    wr_meas = reg_wr_en && (reg_addr == `HTS_ADDR_MEAS_CFG);
    trig_set = wr_meas && reg_wr_data[`HTS_BIT_TRIGGER];
    soft_clr = soft_reset_reg;
    rate = hts_ctrl_pkg::hts_rate_t'(dev_cfg_reg[`HTS_RATE_MSB:`HTS_RATE_LSB]);
    period_ms = rate_period_ms(rate);
  end

  // soft reset request stands one cycle, then the config registers and conversion state return to defaults
  always_ff @(posedge sys_clk) begin
    // a fresh request in the clearing cycle wins, so it is never lost
    if (!rst_n) begin
      soft_reset_reg <= 1'b0;
    end else begin
      soft_reset_reg <= wr_dev && reg_wr_data[`HTS_BIT_SOFT_RESET];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      nvm_reload <= 1'b0;
    end else begin
      nvm_reload <= soft_clr;
    end
  end

  // device configuration; the soft reset bit itself lives in soft_reset_reg
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_clr) begin
      dev_cfg_reg <= `HTS_DEV_CFG_RST;
    end else if (wr_dev) begin
      dev_cfg_reg <= {1'b0, reg_wr_data[6:0]};
    end
  end

  // measurement configuration; a trigger write of 0 leaves the bit alone,
  // and a new trigger set wins over the done clear in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_clr) begin
      meas_cfg_reg <= `HTS_MEAS_CFG_RST;
    end else begin
      if (wr_meas) begin
        meas_cfg_reg[7:1] <= reg_wr_data[7:1];
      end
      if (trig_set) begin
        meas_cfg_reg[`HTS_BIT_TRIGGER] <= 1'b1;
      end else if (conv_done && conv_state_reg == hts_ctrl_pkg::HTS_CONV_BUSY) begin
        meas_cfg_reg[`HTS_BIT_TRIGGER] <= 1'b0;
      end
    end
  end

  // millisecond time base
  always_ff @(posedge sys_clk) begin
    if (!rst_n || ms_div_reg == 32'(MS_TICK_CYCLES - 1)) begin
      ms_div_reg <= 32'h00000000;
    end else begin
      ms_div_reg <= ms_div_reg + 32'h00000001;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      ms_tick_reg <= 1'b0;
    end else begin
      ms_tick_reg <= (ms_div_reg == 32'(MS_TICK_CYCLES - 1));
    end
  end

  // sampling interval; restarts on any device configuration write so a new rate
  // takes a full period rather than inheriting a partial one
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_clr || wr_dev || rate == hts_ctrl_pkg::HTS_RATE_OFF) begin
      period_cnt_reg <= 17'h00000;
    end else if (ms_tick_reg) begin
      if (period_cnt_reg == period_ms - 17'h00001) begin
        period_cnt_reg <= 17'h00000;
      end else begin
        period_cnt_reg <= period_cnt_reg + 17'h00001;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_clr || wr_dev) begin
      auto_tick_reg <= 1'b0;
    end else begin
      auto_tick_reg <= ms_tick_reg && rate != hts_ctrl_pkg::HTS_RATE_OFF
                       && period_cnt_reg == period_ms - 17'h00001;
    end
  end

  // conversion sequencing; an auto sample due while busy is dropped,
  // which keeps a too-fast rate from piling up conversions
  always_ff @(posedge sys_clk) begin
    if (!rst_n || soft_clr) begin
      conv_state_reg <= hts_ctrl_pkg::HTS_CONV_IDLE;
      conv_start <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      case (conv_state_reg)
        hts_ctrl_pkg::HTS_CONV_IDLE: begin
          if (meas_cfg_reg[`HTS_BIT_TRIGGER] || auto_tick_reg) begin
            conv_start <= 1'b1;
            conv_state_reg <= hts_ctrl_pkg::HTS_CONV_BUSY;
          end
        end
        hts_ctrl_pkg::HTS_CONV_BUSY: begin
          if (conv_done) begin
            conv_state_reg <= hts_ctrl_pkg::HTS_CONV_IDLE;
          end
        end
        default: conv_state_reg <= hts_ctrl_pkg::HTS_CONV_IDLE;
      endcase
    end
  end

  // configuration outputs held in their own flops
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      heater_on <= 1'b0;
      alert_mode <= 1'b0;
      temp_resolution <= 2'h0;
      humidity_resolution <= 2'h0;
      measurement_select <= 2'h0;
    end else begin
      heater_on <= dev_cfg_reg[`HTS_BIT_HEATER];
      alert_mode <= dev_cfg_reg[`HTS_BIT_ALERT_MODE];
      temp_resolution <= meas_cfg_reg[`HTS_TEMP_RESOLUTION_MSB:`HTS_TEMP_RESOLUTION_LSB];
      humidity_resolution <= meas_cfg_reg[`HTS_HUMIDITY_RESOLUTION_MSB:`HTS_HUMIDITY_RESOLUTION_LSB];
      measurement_select <= meas_cfg_reg[`HTS_MSEL_MSB:`HTS_MSEL_LSB];
    end
  end

  // alert pin: released while disabled, level follows polarity
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      alert_pin_oe_n <= 1'b1;
      alert_pin_out <= 1'b1;
    end else begin
      alert_pin_oe_n <= !dev_cfg_reg[`HTS_BIT_ALERT_EN];
      alert_pin_out <= dev_cfg_reg[`HTS_BIT_ALERT_POL] ? alert_active : !alert_active;
    end
  end

  // read port; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      reg_rd_data <= 8'h00;
    end else if (reg_rd_en) begin
      if (reg_addr == `HTS_ADDR_DEV_CFG) begin
        reg_rd_data <= {soft_reset_reg, dev_cfg_reg[6:0]};
      end else if (reg_addr == `HTS_ADDR_MEAS_CFG) begin
        reg_rd_data <= meas_cfg_reg;
      end else if (reg_addr == `HTS_ADDR_MAKER_LO) begin
        reg_rd_data <= MAKER_CODE[7:0];
      end else if (reg_addr == `HTS_ADDR_MAKER_HI) begin
        reg_rd_data <= MAKER_CODE[15:8];
      end else if (reg_addr == `HTS_ADDR_PART_LO) begin
        reg_rd_data <= PART_CODE[7:0];
      end else if (reg_addr == `HTS_ADDR_PART_HI) begin
        reg_rd_data <= PART_CODE[15:8];
      end else begin
        reg_rd_data <= 8'h00;
      end
    end
  end

  property p_soft_reset;
    @(posedge sys_clk) disable iff (!rst_n)
    soft_reset_reg |=> (!soft_reset_reg || $past(wr_dev)) && dev_cfg_reg == 8'h00 && meas_cfg_reg == 8'h00
      && nvm_reload;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset did not clear");

  property p_no_auto;
    @(posedge sys_clk) disable iff (!rst_n)
    rate == hts_ctrl_pkg::HTS_RATE_OFF |-> !auto_tick_reg;
  endproperty
  a_no_auto: assert property (p_no_auto) else $error("auto sample with rate off");

  property p_auto_start;
    @(posedge sys_clk) disable iff (!rst_n)
    auto_tick_reg && conv_state_reg == hts_ctrl_pkg::HTS_CONV_IDLE && !soft_clr |=> conv_start;
  endproperty
  a_auto_start: assert property (p_auto_start) else $error("auto sample lost");

  property p_heater;
    @(posedge sys_clk) disable iff (!rst_n)
    wr_dev && !soft_clr |=> ##1 heater_on == $past(reg_wr_data[`HTS_BIT_HEATER], 2);
  endproperty
  a_heater: assert property (p_heater) else $error("heater not following write");

  property p_alert_pin;
    @(posedge sys_clk) disable iff (!rst_n)
    !dev_cfg_reg[`HTS_BIT_ALERT_EN] ##1 !dev_cfg_reg[`HTS_BIT_ALERT_EN] |-> alert_pin_oe_n;
  endproperty
  a_alert_pin: assert property (p_alert_pin) else $error("alert pin driven while disabled");

  property p_alert_pol;
    @(posedge sys_clk) disable iff (!rst_n)
    !dev_cfg_reg[`HTS_BIT_ALERT_POL] && alert_active |=> !alert_pin_out;
  endproperty
  a_alert_pol: assert property (p_alert_pol) else $error("active low alert not low");

  property p_trig_start;
    @(posedge sys_clk) disable iff (!rst_n)
    trig_set && conv_state_reg == hts_ctrl_pkg::HTS_CONV_IDLE && !soft_clr |=> ##1 conv_start;
  endproperty
  a_trig_start: assert property (p_trig_start) else $error("trigger did not start");

  property p_trig_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    conv_state_reg == hts_ctrl_pkg::HTS_CONV_BUSY && !conv_done && !soft_clr
      && meas_cfg_reg[`HTS_BIT_TRIGGER] |=> meas_cfg_reg[`HTS_BIT_TRIGGER] && !conv_start;
  endproperty
  a_trig_hold: assert property (p_trig_hold) else $error("second start while busy");

  property p_maker_read;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == `HTS_ADDR_MAKER_HI |=> reg_rd_data == MAKER_CODE[15:8];
  endproperty
  a_maker_read: assert property (p_maker_read) else $error("maker code high wrong");

  property p_part_read;
    @(posedge sys_clk) disable iff (!rst_n)
    reg_rd_en && reg_addr == `HTS_ADDR_PART_LO |=> reg_rd_data == PART_CODE[7:0];
  endproperty
  a_part_read: assert property (p_part_read) else $error("part code low wrong");

endmodule : hts_ctrl_regs

//--- tb/hts_conv_model.sv
// conversion engine model on the far side of the control registers
// assumes conv_start is a one-cycle pulse; answers with conv_done after DELAY cycles
`timescale 1ns/10ps
module hts_conv_model #(
  parameter int DELAY = 20
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // handshake
  input wire logic conv_start,
  output logic conv_done,
  output int n_starts
);
  int cnt_reg;
  // done is never sent with the start itself, so the block always sees a busy phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      cnt_reg <= 0;
      conv_done <= 1'b0;
      n_starts <= 0;
    end else begin
      conv_done <= 1'b0;
      if (conv_start) begin
        cnt_reg <= DELAY;
        n_starts <= n_starts + 1;
      end else if (cnt_reg == 1) begin
        conv_done <= 1'b1;
        cnt_reg <= 0;
      end else if (cnt_reg > 1) begin
        cnt_reg <= cnt_reg - 1;
      end
    end
  end
endmodule : hts_conv_model

//--- tb/hts_ctrl_regs_tb_top.sv
// self-checking bench for the sensor control registers
// assumes a 1 ms tick shortened to 2 cycles so every auto period scales by 2
`timescale 1ns/10ps
module hts_ctrl_regs_tb_top;
  localparam logic [15:0] MK = 16'h3c69; // arbitrary value
  localparam logic [15:0] PT = 16'h4b17; // arbitrary value
  localparam int LIMIT = 60000;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr_en = 1'b0;
  logic [7:0] reg_wr_data = 8'h00;
  logic reg_rd_en = 1'b0;
  logic alert_active = 1'b0;
  logic [7:0] reg_rd_data, rdv;
  logic conv_start, conv_done, nvm_reload, heater_on, alert_mode, alert_pin_out, alert_pin_oe_n;
  logic [1:0] temp_resolution, humidity_resolution, measurement_select;
  int failures = 0;
  int n_compared = 0;
  int cycles = 0;
  int n_starts, n, k;
  int per [8] = '{0, 120000, 60000, 10000, 5000, 1000, 500, 200};
  always #12.5 sys_clk = ~sys_clk;
  hts_ctrl_regs #(.MS_TICK_CYCLES(2), .MAKER_CODE(MK), .PART_CODE(PT)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en),
    .reg_rd_data(reg_rd_data), .conv_start(conv_start), .conv_done(conv_done),
    .temp_resolution(temp_resolution), .humidity_resolution(humidity_resolution),
    .measurement_select(measurement_select), .nvm_reload(nvm_reload), .heater_on(heater_on),
    .alert_active(alert_active), .alert_mode(alert_mode), .alert_pin_out(alert_pin_out),
    .alert_pin_oe_n(alert_pin_oe_n));
  hts_conv_model #(.DELAY(20)) engine (.sys_clk(sys_clk), .rst_n(rst_n), .conv_start(conv_start),
    .conv_done(conv_done), .n_starts(n_starts));
  task complete_run;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      failures++;
      complete_run();
    end
  end
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wr_data = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask : wr
  // the extra full cycle leaves room for a registered read answer
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    @(negedge sys_clk);
    d = reg_rd_data;
  endtask : rd
  task wait_start(input int lim, output int cnt);
    cnt = 0;
    while (conv_start !== 1'b1 && cnt < lim) begin
      @(posedge sys_clk);
      #1;
      cnt++;
    end
  endtask : wait_start
  task t_reset;
    rd(8'h0e, rdv);
    chk("dev_cfg", rdv, 8'h00);
    rd(8'h0f, rdv);
    chk("meas_cfg", rdv, 8'h00);
    chk("heater", heater_on, 1'b0);
    chk("oe_n", alert_pin_oe_n, 1'b1);
    chk("mode", alert_mode, 1'b0);
    wait_start(500, n);
    chk("no_auto", n, 500);
    $display("reset test done");
  endtask : t_reset
  task t_ids;
    wr(8'hfc, 8'h00);
    wr(8'hff, 8'h00);
    rd(8'hfc, rdv);
    chk("mk_lo", rdv, MK[7:0]);
    rd(8'hfd, rdv);
    chk("mk_hi", rdv, MK[15:8]);
    rd(8'hfe, rdv);
    chk("pt_lo", rdv, PT[7:0]);
    rd(8'hff, rdv);
    chk("pt_hi", rdv, PT[15:8]);
    rd(8'h10, rdv);
    chk("unmapped", rdv, 8'h00);
    $display("id test done");
  endtask : t_ids
  task t_alert;
    wr(8'h0e, 8'h0f);
    alert_active = 1'b1;
    repeat (2) @(negedge sys_clk);
    chk("heater", heater_on, 1'b1);
    chk("oe_n", alert_pin_oe_n, 1'b0);
    chk("out_hi", alert_pin_out, 1'b1);
    chk("mode", alert_mode, 1'b1);
    alert_active = 1'b0;
    repeat (2) @(negedge sys_clk);
    chk("out_hi_idle", alert_pin_out, 1'b0);
    wr(8'h0e, 8'h04);
    repeat (2) @(negedge sys_clk);
    chk("out_lo_idle", alert_pin_out, 1'b1);
    chk("mode0", alert_mode, 1'b0);
    chk("heater0", heater_on, 1'b0);
    wr(8'h0e, 8'h00);
    repeat (2) @(negedge sys_clk);
    chk("oe_n_off", alert_pin_oe_n, 1'b1);
    $display("alert test done");
  endtask : t_alert
  task t_meas;
    logic [1:0] t, h, m;
    for (int i = 0; i < 3; i++) begin
      t = 2'(i);
      h = 2'((i + 1) % 3);
      m = 2'(i % 2);
      wr(8'h0f, {t, h, 1'b0, m, 1'b0});
      repeat (2) @(negedge sys_clk);
      chk("temp_resolution", temp_resolution, t);
      chk("humidity_resolution", humidity_resolution, h);
      chk("msel", measurement_select, m);
      rd(8'h0f, rdv);
      chk("meas_rb", rdv, {t, h, 1'b0, m, 1'b0});
    end
    wr(8'h0f, 8'h00);
    $display("resolution test done");
  endtask : t_meas
  task t_trigger;
    k = n_starts;
    wr(8'h0f, 8'h01);
    wait_start(10, n);
    chk("start_lat", n, 1);
    wr(8'h0f, 8'h01);
    rd(8'h0f, rdv);
    chk("trig_busy", rdv, 8'h01);
    repeat (40) @(negedge sys_clk);
    chk("one_start", n_starts, k + 1);
    rd(8'h0f, rdv);
    chk("trig_clear", rdv, 8'h00);
    $display("trigger test done");
  endtask : t_trigger
  task t_auto;
    for (int c = 3; c < 8; c++) begin
      wr(8'h0e, {1'b0, 3'(c), 4'h0});
      wait_start(2 * per[c] + 20, n);
      chk("period", n >= 2 * per[c] - 4 && n <= 2 * per[c] + 6, 1'b1);
    end
    for (int c = 1; c < 3; c++) begin
      wr(8'h0e, {1'b0, 3'(c), 4'h0});
      wait_start(2000, n);
      chk("slow_rate", n, 2000);
    end
    wr(8'h0e, 8'h00);
    $display("auto rate test done");
  endtask : t_auto
  task t_soft;
    wr(8'h0f, 8'h52);
    wr(8'h0e, 8'h0f);
    wr(8'h0e, 8'h8f);
    k = 0;
    while (nvm_reload !== 1'b1 && k < 8) begin
      @(posedge sys_clk);
      #1;
      k++;
    end
    chk("reload", k < 8, 1'b1);
    @(posedge sys_clk);
    #1;
    chk("reload_pulse", nvm_reload, 1'b0);
    rd(8'h0e, rdv);
    chk("dev_def", rdv, 8'h00);
    rd(8'h0f, rdv);
    chk("meas_def", rdv, 8'h00);
    chk("heater_def", heater_on, 1'b0);
    $display("soft reset test done");
  endtask : t_soft
  initial begin
    repeat (16) @(negedge sys_clk);
    rst_n = 1'b1;
    t_reset();
    t_ids();
    t_alert();
    t_meas();
    t_trigger();
    t_auto();
    t_soft();
    complete_run();
  end
endmodule : hts_ctrl_regs_tb_top
